/* rtl/amgpc_cfg_if.sv */
// Interface carrying the decoded configuration from the decoder to the top.
`default_nettype none
interface amgpc_cfg_if;
    logic [7:0] gain;
    logic gain_valid;
    amgpc_pkg::amgpc_pwr_t pwr;
    logic pin_reset;
    modport dec (output gain, gain_valid, pwr, pin_reset);
    modport top (input gain, gain_valid, pwr, pin_reset);
endinterface
`default_nettype wire

/* rtl/amgpc_decode.sv */
// Combinational decoder of gain-select and power-down pin codes.
`default_nettype none
module amgpc_decode (
    input wire logic [3:0] gain_sel_i,
    input wire logic [2:0] pwr_sel_i,
    amgpc_cfg_if.dec cfg
);
    always_comb
    begin
        cfg.gain_valid = 1'b1;
        case (gain_sel_i)
            4'h1: cfg.gain = 8'd1;
            4'h2: cfg.gain = 8'd2;
            4'h3: cfg.gain = 8'd3;
            4'h4: cfg.gain = 8'd4;
            4'h5: cfg.gain = 8'd6;
            4'h6: cfg.gain = 8'd8;
            4'h7: cfg.gain = 8'd12;
            4'h8: cfg.gain = 8'd16;
            4'h9: cfg.gain = 8'd24;
            4'ha: cfg.gain = 8'd32;
            4'hb: cfg.gain = 8'd48;
            4'hc: cfg.gain = 8'd64;
            4'hd: cfg.gain = 8'd96;
            4'he: cfg.gain = 8'd128;
            default:
            begin
                cfg.gain = amgpc_pkg::GAIN_DEFAULT;
                cfg.gain_valid = 1'b0;
            end
        endcase
        cfg.pin_reset = (pwr_sel_i == amgpc_pkg::PWR_RESET);
        case (pwr_sel_i)
            amgpc_pkg::PWR_ADC_ONLY: cfg.pwr = 3'h1;
            amgpc_pkg::PWR_FAST_ONLY: cfg.pwr = 3'h2;
            amgpc_pkg::PWR_LOWP_ONLY: cfg.pwr = 3'h4;
            amgpc_pkg::PWR_CMP_ONLY: cfg.pwr = 3'h6;
            amgpc_pkg::PWR_ALL_ON: cfg.pwr = 3'h7;
            default: cfg.pwr = 3'h0;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/amgpc_pkg.sv */
// Package of constants and types for the ADC mode, gain and power-down control block.
`default_nettype none
package amgpc_pkg;
    // =========================================================
    // Power-down pin codes
    localparam logic [2:0] PWR_ALL_OFF = 3'h0;
    localparam logic [2:0] PWR_ADC_ONLY = 3'h1;
    localparam logic [2:0] PWR_FAST_ONLY = 3'h2;
    localparam logic [2:0] PWR_LOWP_ONLY = 3'h3;
    localparam logic [2:0] PWR_CMP_ONLY = 3'h4;
    localparam logic [2:0] PWR_ALL_ON = 3'h5;
    localparam logic [2:0] PWR_RESET = 3'h7;
    // =========================================================
    // Gain codes and reset values
    localparam logic [3:0] GAIN_SW_MODE = 4'h0;
    localparam logic [3:0] GAIN_RESERVED = 4'hf;
    localparam logic [7:0] GAIN_DEFAULT = 8'h01;
    localparam logic [3:0] GAIN_CODE_RST = 4'h0;
    // =========================================================
    // Power-up waits
    localparam int CLK_MHZ = 100;
    localparam int T_EXT_US = 15;
    localparam int T_INT_US = 240;
    localparam int EXT_CYCLES = T_EXT_US * CLK_MHZ;
    localparam int INT_CYCLES = T_INT_US * CLK_MHZ;
    // =========================================================
    // Power enables: {low-power pair, fast pair, converters}
    typedef logic [2:0] amgpc_pwr_t;
    typedef enum logic {AMGPC_PIN_MODE, AMGPC_REG_MODE} amgpc_mode_t;
endpackage
`default_nettype wire

/* rtl/amgpc_top.sv */
// Mode, gain and power-down control front end of a dual sampling converter.
//
// Contract
// - Any gain-select pin high means pin mode; all low means register mode.
// - Pin codes 1 to 14 map to gains 1,2,3,4,6,8,12,16,24,32,48,64,96,128.
// - Pin mode takes gain, power, reference and calibration straight from pins.
// - Power code 101 turns on both comparator pairs and both converters.
// - Codes 001,010,011,100 give converters, fast pair, low-power pair, both pairs.
// - Power code 000 in pin mode turns everything off.
// - Power code 111 resets the device in pin mode only, all off.
// - A pin reset sets gain to 1, clears power, ready and the wait count, and leaves everything powered down.
// - At power-up mode comes from gain pins; registers start at zero except gain at 1 and the mode flag at 1.
// - Register-mode power-up keeps all off with gain 1.
// - External reference needs 15 us after power-up before use.
// - Internal reference needs 240 us after power-up before use.
// - Reference-select high picks internal reference; low picks external.
// - In register mode the lowest power-down pin is serial data input.
`default_nettype none
module amgpc_top #(
    parameter int EXT_WAIT = amgpc_pkg::EXT_CYCLES,
    parameter int INT_WAIT = amgpc_pkg::INT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] gain_sel_i,
    input wire logic [2:0] pwr_sel_i,
    input wire logic internal_ref_select_i,
    input wire logic cal_start_i,
    input wire logic [7:0] reg_gain_i,
    input wire logic [2:0] reg_pwr_i,
    input wire logic reg_write_i,
    output logic reg_mode_o,
    output logic [7:0] gain_o,
    output logic lowp_cmp_on_o,
    output logic fast_cmp_on_o,
    output logic adc_on_o,
    output logic internal_ref_o,
    output logic cal_start_o,
    output logic serial_din_o,
    output logic pin_reset_o,
    output logic ready_o
);
    // =========================================================
    // Decoding.
    amgpc_cfg_if cfg ();
    amgpc_decode u_dec (
        .gain_sel_i(gain_sel_i),
        .pwr_sel_i(pwr_sel_i),
        .cfg(cfg)
    );

    // =========================================================
    // State.
    logic [7:0] gain_reg, gain_next;
    logic [2:0] pwr_reg, pwr_next;
    logic reg_mode_reg, reg_mode_next;
    logic ref_reg, ref_next;
    logic cal_reg, cal_next;
    logic din_reg, din_next;
    logic rst_reg, rst_next;
    logic ready_reg, ready_next;
    logic [31:0] wait_reg, wait_next;
    logic in_reg_mode;

    assign in_reg_mode = (gain_sel_i == amgpc_pkg::GAIN_SW_MODE);

    always_comb
    begin
        gain_next = gain_reg;
        pwr_next = pwr_reg;
        reg_mode_next = in_reg_mode;
        ref_next = internal_ref_select_i;
        cal_next = 1'b0;
        din_next = 1'b0;
        rst_next = 1'b0;
        ready_next = ready_reg;
        wait_next = wait_reg;
        if (in_reg_mode)
        begin
            din_next = pwr_sel_i[0];
            if (reg_write_i)
            begin
                gain_next = reg_gain_i;
                pwr_next = reg_pwr_i;
            end
        end
        else if (cfg.pin_reset)
        begin
            gain_next = amgpc_pkg::GAIN_DEFAULT;
            pwr_next = 3'h0;
            rst_next = 1'b1;
            ready_next = 1'b0;
            wait_next = 32'h0;
        end
        else
        begin
            if (cfg.gain_valid)
            begin
                gain_next = cfg.gain;
            end
            pwr_next = cfg.pwr;
            cal_next = cal_start_i;
        end
        if (!ready_reg && !cfg.pin_reset | in_reg_mode)
        begin
            wait_next = wait_reg + 32'h1;
            if (wait_reg + 32'h1 >= (ref_reg ? 32'(INT_WAIT) : 32'(EXT_WAIT)))
            begin
                ready_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            gain_reg <= amgpc_pkg::GAIN_DEFAULT;
            pwr_reg <= 3'h0;
            reg_mode_reg <= 1'b1;
            ref_reg <= 1'b0;
            cal_reg <= 1'b0;
            din_reg <= 1'b0;
            rst_reg <= 1'b0;
            ready_reg <= 1'b0;
            wait_reg <= 32'h0;
        end
        else
        begin
            gain_reg <= gain_next;
            pwr_reg <= pwr_next;
            reg_mode_reg <= reg_mode_next;
            ref_reg <= ref_next;
            cal_reg <= cal_next;
            din_reg <= din_next;
            rst_reg <= rst_next;
            ready_reg <= ready_next;
            wait_reg <= wait_next;
        end
    end

    assign reg_mode_o = reg_mode_reg;
    assign gain_o = gain_reg;
    assign lowp_cmp_on_o = pwr_reg[2];
    assign fast_cmp_on_o = pwr_reg[1];
    assign adc_on_o = pwr_reg[0];
    assign internal_ref_o = ref_reg;
    assign cal_start_o = cal_reg;
    assign serial_din_o = din_reg;
    assign pin_reset_o = rst_reg;
    assign ready_o = ready_reg;

    // =========================================================
    // Checks.
    a_pin_reset_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i != 4'h0 && pwr_sel_i == 3'h7) |=> (pwr_reg == 3'h0 && rst_reg))
        else $error("pin reset left power on");
    a_all_on_code: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i != 4'h0 && pwr_sel_i == 3'h5) |=> (pwr_reg == 3'h7))
        else $error("all-on code not applied");
    a_all_off_code: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i != 4'h0 && pwr_sel_i == 3'h0) |=> (pwr_reg == 3'h0))
        else $error("all-off code not applied");
    a_fast_code: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i != 4'h0 && pwr_sel_i == 3'h2) |=> (pwr_reg == 3'h2))
        else $error("fast pair code wrong");
    a_gain_pin_map: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i == 4'he && pwr_sel_i != 3'h7) |=> (gain_reg == 8'd128))
        else $error("gain 128 not applied");
    a_gain_reserved: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i == 4'hf && pwr_sel_i != 3'h7) |=> $stable(gain_reg))
        else $error("reserved gain changed gain");
    a_mode_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> (reg_mode_reg == ($past(gain_sel_i) == 4'h0)))
        else $error("mode does not follow gain pins");
    a_ref_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> (ref_reg == $past(internal_ref_select_i)))
        else $error("reference select not followed");
    a_reg_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i == 4'h0 && !reg_write_i) |=> $stable(pwr_reg))
        else $error("power changed without write");
    // =========================================================
    // Pass-through, register-write and wait checks.
    // These guard the outputs that the code checks above do not reach.
    a_cal_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i != 4'h0 && pwr_sel_i != 3'h7) |=> (cal_reg == $past(cal_start_i)))
        else $error("calibration pin not followed");
    a_din_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> (din_reg == ($past(gain_sel_i) == 4'h0 && $past(pwr_sel_i[0]))))
        else $error("serial data pin not followed");
    a_reg_pwr_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i == 4'h0 && reg_write_i) |=> (pwr_reg == $past(reg_pwr_i)))
        else $error("register power write not applied");
    a_reg_gain_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i == 4'h0 && reg_write_i) |=> (gain_reg == $past(reg_gain_i)))
        else $error("register gain write not applied");
    a_ready_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i != 4'h0 && pwr_sel_i == 3'h7) |=> (!ready_reg && wait_reg == 32'h0))
        else $error("pin reset left ready set");
    a_cal_reg_mode: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_sel_i == 4'h0) |=> (!cal_reg && !rst_reg))
        else $error("pin controls acted in register mode");
    a_ready_wait: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(ready_reg) |-> (wait_reg >= ($past(ref_reg) ? 32'(INT_WAIT) : 32'(EXT_WAIT))))
        else $error("ready raised before power-up wait");
    c_pin_reset: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) rst_reg);
    c_reg_write: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        gain_sel_i == 4'h0 && reg_write_i);
    c_all_on: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) pwr_reg == 3'h7);
    c_ready: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $rose(ready_reg));
endmodule
`default_nettype wire

/* verification/amgpc_host.sv */
// Host model that drives the configuration and power-down pins.
`default_nettype none
module amgpc_host (
    input wire logic clk_i,
    input wire logic [3:0] g_cmd_i,
    input wire logic [2:0] p_cmd_i,
    input wire logic ref_cmd_i,
    input wire logic cal_cmd_i,
    output logic [3:0] gain_sel_o = 4'h0,
    output logic [2:0] pwr_sel_o = 3'h0,
    output logic ref_o = 1'b0,
    output logic cal_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins change just after an edge, then stand; in register mode the upper pins stay low.
    always @(posedge clk_i)
    begin
        gain_sel_o <= g_cmd_i;
        pwr_sel_o <= (g_cmd_i == 4'h0) ? {2'h0, p_cmd_i[0]} : p_cmd_i;
        ref_o <= ref_cmd_i;
        cal_o <= cal_cmd_i;
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the mode, gain and power-down control block.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EXT_W = 5;
    localparam int INT_W = 20;
    localparam logic [7:0] GTAB [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c,
        8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80};
    localparam logic [2:0] PTAB [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] g_cmd = 4'h0;
    logic [2:0] p_cmd = 3'h0;
    logic ref_cmd = 1'b0;
    logic cal_cmd = 1'b0;
    logic [7:0] reg_gain = 8'h00;
    logic [2:0] reg_pwr = 3'h0;
    logic reg_write = 1'b0;
    logic chk = 1'b0;
    logic [3:0] gain_sel;
    logic [2:0] pwr_sel;
    logic [7:0] gain;
    logic ref_pin, cal_pin, reg_mode, lowp_on, fast_on, adc_on;
    logic int_ref, cal_out, sdin, prst, ready;
    logic [15:0] exp_q [$];
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    amgpc_host amgpc_host_inst (.clk_i(sys_clk_i), .g_cmd_i(g_cmd), .p_cmd_i(p_cmd),
        .ref_cmd_i(ref_cmd), .cal_cmd_i(cal_cmd), .gain_sel_o(gain_sel), .pwr_sel_o(pwr_sel),
        .ref_o(ref_pin), .cal_o(cal_pin));
    amgpc_top #(.EXT_WAIT(EXT_W), .INT_WAIT(INT_W)) amgpc_top_inst (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .gain_sel_i(gain_sel), .pwr_sel_i(pwr_sel),
        .internal_ref_select_i(ref_pin), .cal_start_i(cal_pin), .reg_gain_i(reg_gain),
        .reg_pwr_i(reg_pwr), .reg_write_i(reg_write), .reg_mode_o(reg_mode), .gain_o(gain),
        .lowp_cmp_on_o(lowp_on), .fast_cmp_on_o(fast_on), .adc_on_o(adc_on),
        .internal_ref_o(int_ref), .cal_start_o(cal_out), .serial_din_o(sdin),
        .pin_reset_o(prst), .ready_o(ready));
    initial
    begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // =========================================================
    // Checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        compares++;
        if (seen !== expv)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [15:0] ex(input logic m, input logic [7:0] g, input logic [2:0] p,
        input logic pr, input logic rf, input logic cl, input logic dn);
        return {m, g, p, pr, rf, cl, dn};
    endfunction
    always @(negedge sys_clk_i)
        if (chk)
            check({reg_mode, gain, lowp_on, fast_on, adc_on, prst, int_ref, cal_out, sdin},
                exp_q.pop_front());
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            end_sim();
        end
    end
    // =========================================================
    // Stimulus
    task automatic apply(input logic [3:0] g, input logic [2:0] p, input logic r, input logic c,
        input logic [15:0] e);
        @(posedge sys_clk_i);
        g_cmd <= g;
        p_cmd <= p;
        ref_cmd <= r;
        cal_cmd <= c;
        exp_q.push_back(e);
        repeat (2) @(posedge sys_clk_i);
        chk <= 1'b1;
        @(posedge sys_clk_i);
        chk <= 1'b0;
    endtask
    task automatic wait_ready(input int lo, input int hi);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < hi)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check({15'h0, n >= lo && ready === 1'b1}, 16'h0001);
    endtask
    initial
    begin
        logic r;
        logic c;
        void'($urandom(27566));
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        wait_ready(EXT_W - 1, EXT_W + 4);
        apply(4'h0, 3'h0, 1'b0, 1'b0, ex(1'b1, 8'h01, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        $display("test powerup done");
        for (int i = 0; i < 14; i++)
        begin
            r = 1'($urandom);
            c = 1'($urandom);
            apply(4'(i + 1), 3'h5, r, c, ex(1'b0, GTAB[i], 3'h7, 1'b0, r, c, 1'b0));
        end
        $display("test gain table done");
        for (int i = 0; i < 6; i++)
            apply(4'h2, 3'(i), 1'b0, 1'b0, ex(1'b0, 8'h02, PTAB[i], 1'b0, 1'b0, 1'b0, 1'b0));
        apply(4'hf, 3'h5, 1'b0, 1'b0, ex(1'b0, 8'h02, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0));
        $display("test power codes done");
        apply(4'h1, 3'h7, 1'b1, 1'b1, ex(1'b0, 8'h01, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0));
        @(negedge sys_clk_i);
        check({15'h0, ready}, 16'h0000);
        @(posedge sys_clk_i);
        p_cmd <= 3'h5;
        wait_ready(INT_W - 1, INT_W + 6);
        $display("test pin reset done");
        @(posedge sys_clk_i);
        g_cmd <= 4'h0;
        p_cmd <= 3'h1;
        reg_gain <= 8'h20;
        reg_pwr <= 3'h5;
        repeat (3) @(posedge sys_clk_i);
        reg_write <= 1'b1;
        @(posedge sys_clk_i);
        reg_write <= 1'b0;
        apply(4'h0, 3'h1, 1'b1, 1'b1, ex(1'b1, 8'h20, 3'h5, 1'b0, 1'b1, 1'b0, 1'b1));
        $display("test register mode done");
        end_sim();
    end
endmodule
`default_nettype wire
